// >>> hw/rws_pkg.sv
package rws_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // clocks and times
  localparam int CORE_CLK_MHZ = 250;
  localparam int REF_CLK_MHZ = 25;
  localparam int REF_LOSS_NS = 200;
  localparam int RST_STRETCH_NS = 100;
  localparam int REF_CNT_W = 6;
  localparam int RST_CNT_W = 5;
  // longest time, rounded down
  localparam logic [REF_CNT_W-1:0] REF_LOSS_CYC = REF_CNT_W'(REF_LOSS_NS * CORE_CLK_MHZ / 1000);
  // least time, rounded up
  localparam logic [RST_CNT_W-1:0] RST_STRETCH_CYC = RST_CNT_W'((RST_STRETCH_NS * CORE_CLK_MHZ + 999) / 1000);

  //////////////////////////////////////////////////////////////////////////////
  // synchronised pin bundle
  localparam int PIN_HW_RST = 0;
  localparam int PIN_CS = 1;
  localparam int PIN_WR = 2;
  localparam int PIN_RD = 3;
  localparam int PIN_XOVER = 4;
  localparam int PIN_SPEED = 5;
  localparam int PIN_REF = 6;
  localparam int PIN_W = 7;
  // ref 0, speed 1, xover 0, strobes idle high, hw reset asserted
  localparam logic [PIN_W-1:0] PIN_RST_VAL = 7'h2E;

  //////////////////////////////////////////////////////////////////////////////
  // reset values and defaults
  localparam logic WRITE_ALLOW_RST = 1'b0;
  localparam logic WAKE_IND_RST = 1'b0;
  localparam logic SPEED_STRAP_RST = 1'b1;
  localparam logic DEF_FULL_DUPLEX = 1'b0;

  typedef enum logic [2:0] {
    RWS_ACTIVE = 3'b001,
    RWS_SLEEP = 3'b010,
    RWS_WAKE = 3'b100
  } rws_pwr_e;

endpackage

// >>> hw/rws_sync.sv
`timescale 1ns/1ns
`default_nettype none

module rws_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  // pins
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] sync_r;
  logic [W-1:0] sync_nxt;

  //////////////////////////////////////////////////////////////////////////////
  // two-stage synchroniser
  always_comb begin
    meta_nxt = i_clk_en ? i_async : meta_r;
    sync_nxt = i_clk_en ? meta_r : sync_r;
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      meta_r <= RST_VAL;
      sync_r <= RST_VAL;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign o_sync = sync_r;

endmodule

`default_nettype wire

// >>> hw/rws_ctrl.sv
`timescale 1ns/1ns
`default_nettype none

module rws_ctrl
  import rws_pkg::*;
(
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  // reference oscillator
  input wire logic i_ref_osc_in,
  output logic o_ref_osc_out,
  output logic o_ref_clk_ok,
  // external reset and distributed reset
  input wire logic i_hw_rst_l,
  output logic o_core_rst,
  // host strobes
  input wire logic i_chip_sel_l,
  input wire logic i_write_strobe_l,
  input wire logic i_read_strobe_l,
  output logic o_write_allow,
  output logic o_write_accept,
  output logic o_write_drop,
  // power state
  input wire logic i_sleep_req,
  output logic o_power_save,
  output logic o_wake_done,
  // wake indicator
  input wire logic i_wake_event,
  input wire logic i_wake_en,
  input wire logic i_wake_pol,
  input wire logic i_wake_od,
  input wire logic i_wake_clr,
  output logic o_wake_indicator_o,
  output logic o_wake_indicator_oe_l,
  // straps
  input wire logic i_crossover_auto_strap,
  input wire logic i_speed_strap,
  output logic o_auto_xover_en,
  output logic o_def_speed_100,
  output logic o_def_full_duplex,
  output logic o_def_autoneg
);

  import rws_pkg::*;

  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] pin_s;
  logic core_rst_r, core_rst_nxt;
  logic [RST_CNT_W-1:0] rst_cnt_r, rst_cnt_nxt;
  logic rst_release;
  logic rst_now;
  rws_pwr_e state_r, state_nxt;
  logic wr_cyc, rd_cyc, wr_start, rd_start;
  logic wr_cyc_prev_r, wr_cyc_prev_nxt, rd_cyc_prev_r, rd_cyc_prev_nxt;
  logic write_allow_r, write_allow_nxt;
  logic accept_r, accept_nxt, drop_r, drop_nxt;
  logic psave_r, psave_nxt, wake_done_r, wake_done_nxt;
  logic wake_ind_r, wake_ind_nxt, ind_o_r, ind_o_nxt, ind_oe_l_r, ind_oe_l_nxt;
  logic ind_level;
  logic xover_r, xover_nxt, speed_r, speed_nxt;
  logic ref_prev_r, ref_prev_nxt, ref_ok_r, ref_ok_nxt, ref_out_r, ref_out_nxt;
  logic [REF_CNT_W-1:0] ref_cnt_r, ref_cnt_nxt;

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  assign pin_raw = {i_ref_osc_in, i_speed_strap, i_crossover_auto_strap, i_read_strobe_l,
                    i_write_strobe_l, i_chip_sel_l, i_hw_rst_l};

  rws_sync #(
    .W(PIN_W),
    .RST_VAL(PIN_RST_VAL)
  ) u_sync (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_clk_en(i_clk_en),
    .i_async(pin_raw),
    .o_sync(pin_s)
  );

  //////////////////////////////////////////////////////////////////////////////
  // reset distribution with stretch
  always_comb begin
    rst_cnt_nxt = rst_cnt_r;
    core_rst_nxt = core_rst_r;
    if (!pin_s[PIN_HW_RST]) begin
      rst_cnt_nxt = '0;
      core_rst_nxt = 1'b1;
    end else if (rst_cnt_r != RST_STRETCH_CYC) begin
      rst_cnt_nxt = rst_cnt_r + 1'b1;
      core_rst_nxt = 1'b1;
    end else begin
      core_rst_nxt = 1'b0;
    end
  end

  assign rst_release = core_rst_r && !core_rst_nxt;
  // reset seen this cycle or already distributed
  assign rst_now = core_rst_r || core_rst_nxt;

  // power-on reset holds the chain until the pin reads high
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rst_cnt_r <= '0;
      core_rst_r <= 1'b1;
    end else if (i_clk_en) begin
      rst_cnt_r <= rst_cnt_nxt;
      core_rst_r <= core_rst_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // host strobes, write gate and power state
  assign wr_cyc = !pin_s[PIN_CS] && !pin_s[PIN_WR];
  assign rd_cyc = !pin_s[PIN_CS] && !pin_s[PIN_RD];
  assign wr_start = wr_cyc && !wr_cyc_prev_r;
  assign rd_start = rd_cyc && !rd_cyc_prev_r;

  always_comb begin
    state_nxt = state_r;
    write_allow_nxt = write_allow_r;
    wr_cyc_prev_nxt = wr_cyc;
    rd_cyc_prev_nxt = rd_cyc;
    accept_nxt = 1'b0;
    drop_nxt = 1'b0;
    wake_done_nxt = 1'b0;
    case (state_r)
      RWS_ACTIVE: begin
        if (i_sleep_req) begin
          state_nxt = RWS_SLEEP;
          write_allow_nxt = 1'b0;
        end else if (rd_start) begin
          write_allow_nxt = 1'b1;
        end
        accept_nxt = wr_start && write_allow_r;
        drop_nxt = wr_start && !write_allow_r;
      end
      RWS_SLEEP: begin
        write_allow_nxt = 1'b0;
        // only a write cycle or a reset leaves sleep, any address and data
        if (wr_start) begin
          state_nxt = RWS_WAKE;
        end
        drop_nxt = wr_start;
      end
      RWS_WAKE: begin
        state_nxt = RWS_ACTIVE;
        write_allow_nxt = 1'b0;
        wake_done_nxt = 1'b1;
        drop_nxt = wr_start;
      end
      default: begin
        state_nxt = RWS_ACTIVE;
        write_allow_nxt = WRITE_ALLOW_RST;
      end
    endcase
    psave_nxt = (state_nxt == RWS_SLEEP);
    if (rst_now) begin
      state_nxt = RWS_ACTIVE;
      write_allow_nxt = WRITE_ALLOW_RST;
      accept_nxt = 1'b0;
      drop_nxt = 1'b0;
      wake_done_nxt = 1'b0;
      psave_nxt = 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_r <= RWS_ACTIVE;
      write_allow_r <= WRITE_ALLOW_RST;
      wr_cyc_prev_r <= 1'b0;
      rd_cyc_prev_r <= 1'b0;
      accept_r <= 1'b0;
      drop_r <= 1'b0;
      psave_r <= 1'b0;
      wake_done_r <= 1'b0;
    end else if (i_clk_en) begin
      state_r <= state_nxt;
      write_allow_r <= write_allow_nxt;
      wr_cyc_prev_r <= wr_cyc_prev_nxt;
      rd_cyc_prev_r <= rd_cyc_prev_nxt;
      accept_r <= accept_nxt;
      drop_r <= drop_nxt;
      psave_r <= psave_nxt;
      wake_done_r <= wake_done_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // wake indicator, set wins over clear
  always_comb begin
    wake_ind_nxt = wake_ind_r;
    if (i_wake_event && i_wake_en) begin
      wake_ind_nxt = 1'b1;
    end else if (i_wake_clr) begin
      wake_ind_nxt = 1'b0;
    end
    if (rst_now) begin
      wake_ind_nxt = WAKE_IND_RST;
    end
    ind_level = wake_ind_nxt ~^ i_wake_pol;
    ind_o_nxt = i_wake_od ? 1'b0 : ind_level;
    ind_oe_l_nxt = i_wake_od ? ind_level : 1'b0;
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wake_ind_r <= WAKE_IND_RST;
      ind_o_r <= 1'b0;
      ind_oe_l_r <= 1'b1;
    end else if (i_clk_en) begin
      wake_ind_r <= wake_ind_nxt;
      ind_o_r <= ind_o_nxt;
      ind_oe_l_r <= ind_oe_l_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // straps and reference clock watch
  always_comb begin
    xover_nxt = core_rst_r ? 1'b0 : pin_s[PIN_XOVER];
    speed_nxt = rst_release ? pin_s[PIN_SPEED] : speed_r;
    ref_prev_nxt = pin_s[PIN_REF];
    ref_out_nxt = !pin_s[PIN_REF];
    if (pin_s[PIN_REF] != ref_prev_r) begin
      ref_cnt_nxt = '0;
    end else if (ref_cnt_r != REF_LOSS_CYC) begin
      ref_cnt_nxt = ref_cnt_r + 1'b1;
    end else begin
      ref_cnt_nxt = ref_cnt_r;
    end
    ref_ok_nxt = (ref_cnt_nxt != REF_LOSS_CYC);
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      xover_r <= 1'b0;
      speed_r <= SPEED_STRAP_RST;
      ref_prev_r <= 1'b0;
      ref_out_r <= 1'b1;
      ref_cnt_r <= '0;
      ref_ok_r <= 1'b0;
    end else if (i_clk_en) begin
      xover_r <= xover_nxt;
      speed_r <= speed_nxt;
      ref_prev_r <= ref_prev_nxt;
      ref_out_r <= ref_out_nxt;
      ref_cnt_r <= ref_cnt_nxt;
      ref_ok_r <= ref_ok_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs
  assign o_ref_osc_out = ref_out_r;
  assign o_ref_clk_ok = ref_ok_r;
  assign o_core_rst = core_rst_r;
  assign o_write_allow = write_allow_r;
  assign o_write_accept = accept_r;
  assign o_write_drop = drop_r;
  assign o_power_save = psave_r;
  assign o_wake_done = wake_done_r;
  assign o_wake_indicator_o = ind_o_r;
  assign o_wake_indicator_oe_l = ind_oe_l_r;
  assign o_auto_xover_en = xover_r;
  assign o_def_speed_100 = speed_r;
  assign o_def_autoneg = speed_r;
  assign o_def_full_duplex = DEF_FULL_DUPLEX;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);

  property p_rst_hold;
    i_clk_en && !pin_s[PIN_HW_RST] |=> core_rst_r && !o_write_allow && !wake_ind_r;
  endproperty
  a_rst_hold: assert property (p_rst_hold) else $error("reset pin did not reset state");

  property p_rst_stretch;
    $fell(core_rst_r) |-> rst_cnt_r == RST_STRETCH_CYC && $past(pin_s[PIN_HW_RST]);
  endproperty
  a_rst_stretch: assert property (p_rst_stretch) else $error("reset released early");

  property p_write_gate;
    o_write_accept |-> $past(write_allow_r) && $past(state_r) == RWS_ACTIVE;
  endproperty
  a_write_gate: assert property (p_write_gate) else $error("write accepted before a read");

  property p_wake_set;
    i_clk_en && i_wake_event && i_wake_en && !rst_now |=> wake_ind_r;
  endproperty
  a_wake_set: assert property (p_wake_set) else $error("wake event did not raise indicator");

  property p_wake_drive;
    i_clk_en |=> o_wake_indicator_oe_l == ($past(i_wake_od) & (wake_ind_r ~^ $past(i_wake_pol)))
                 && (o_wake_indicator_o == (!$past(i_wake_od) & (wake_ind_r ~^ $past(i_wake_pol))));
  endproperty
  a_wake_drive: assert property (p_wake_drive) else $error("wake indicator drive wrong");

  property p_event_no_wake;
    i_clk_en && state_r == RWS_SLEEP && !wr_start && !rst_now |=> state_r == RWS_SLEEP;
  endproperty
  a_event_no_wake: assert property (p_event_no_wake) else $error("left sleep without a write");

  property p_leave_on_write;
    state_r == RWS_SLEEP ##1 state_r != RWS_SLEEP |-> $past(wr_start) || $past(rst_now);
  endproperty
  a_leave_on_write: assert property (p_leave_on_write) else $error("sleep ended without write");

  property p_any_write_wakes;
    i_clk_en && state_r == RWS_SLEEP && wr_start && !rst_now |=> state_r == RWS_WAKE ##1 !o_power_save;
  endproperty
  a_any_write_wakes: assert property (p_any_write_wakes) else $error("write did not wake");

  property p_xover;
    i_clk_en && !core_rst_r |=> o_auto_xover_en == $past(pin_s[PIN_XOVER]);
  endproperty
  a_xover: assert property (p_xover) else $error("crossover enable not following strap");

  property p_speed_latch;
    $fell(core_rst_r) |-> speed_r == $past(pin_s[PIN_SPEED]);
  endproperty
  a_speed_latch: assert property (p_speed_latch) else $error("speed strap not latched");

  property p_defaults;
    o_def_autoneg == o_def_speed_100 && !o_def_full_duplex;
  endproperty
  a_defaults: assert property (p_defaults) else $error("default link settings wrong");

  property p_strap_hold;
    !core_rst_r && !$past(core_rst_r) |-> $stable(speed_r);
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("latched strap changed");

endmodule

`default_nettype wire

// >>> verification/rws_host_model.sv
`timescale 1ns/1ns
`default_nettype none

module rws_host_model (
  // clock
  input wire logic i_clk,
  // host strobes
  output logic o_chip_sel_l,
  output logic o_write_strobe_l,
  output logic o_read_strobe_l
);
  initial begin
    o_chip_sel_l = 1'b1;
    o_write_strobe_l = 1'b1;
    o_read_strobe_l = 1'b1;
  end

  ////////////////////////////////////////
  // one strobe cycle, held hold cycles, then idle gap
  task automatic access(input logic is_wr, input int hold);
    @(negedge i_clk);
    o_chip_sel_l <= 1'b0;
    o_write_strobe_l <= ~is_wr;
    o_read_strobe_l <= is_wr;
    repeat (hold) @(negedge i_clk);
    o_chip_sel_l <= 1'b1;
    o_write_strobe_l <= 1'b1;
    o_read_strobe_l <= 1'b1;
    repeat (5) @(negedge i_clk);
  endtask

  // read before any write
  task automatic first_read();
    access(1'b0, 4);
  endtask

  // wakeup write, strobe held for four cycles
  task automatic wake_write();
    access(1'b1, 4);
  endtask
endmodule

`default_nettype wire

// >>> verification/test_rws_ctrl.sv
`timescale 1ns/1ns
`default_nettype none

module test_rws_ctrl;
  import rws_pkg::*;

  logic clk, sys_rst, hw_rst_l, ref_in, ref_run, sleep_req, xover, speed, lv;
  logic wake_ev, wake_en, wake_pol, wake_od, wake_clr, cs_l, wr_l, rd_l;
  logic ref_out, ref_ok, core_rst, wr_allow, wr_acc, wr_drop, psave, wdone;
  logic ind_o, ind_oe_l, xen, spd100, fdx, aneg;
  int n_errors = 0;
  int compares = 0;
  int n_acc = 0;
  int n_drop = 0;
  int n_wdone = 0;

  rws_ctrl i_dut (
    .i_core_clk(clk), .i_sys_rst(sys_rst), .i_clk_en(1'b1),
    .i_ref_osc_in(ref_in), .o_ref_osc_out(ref_out), .o_ref_clk_ok(ref_ok),
    .i_hw_rst_l(hw_rst_l), .o_core_rst(core_rst),
    .i_chip_sel_l(cs_l), .i_write_strobe_l(wr_l), .i_read_strobe_l(rd_l),
    .o_write_allow(wr_allow), .o_write_accept(wr_acc), .o_write_drop(wr_drop),
    .i_sleep_req(sleep_req), .o_power_save(psave), .o_wake_done(wdone),
    .i_wake_event(wake_ev), .i_wake_en(wake_en), .i_wake_pol(wake_pol),
    .i_wake_od(wake_od), .i_wake_clr(wake_clr),
    .o_wake_indicator_o(ind_o), .o_wake_indicator_oe_l(ind_oe_l),
    .i_crossover_auto_strap(xover), .i_speed_strap(speed),
    .o_auto_xover_en(xen), .o_def_speed_100(spd100),
    .o_def_full_duplex(fdx), .o_def_autoneg(aneg)
  );

  rws_host_model i_host (
    .i_clk(clk), .o_chip_sel_l(cs_l), .o_write_strobe_l(wr_l), .o_read_strobe_l(rd_l)
  );

  ////////////////////////////////////////
  // clocks and pulse counters
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // 25 MHz reference, toggles on falling edges
  initial begin
    ref_in = 1'b0;
    #4;
    forever begin
      #20;
      if (ref_run) ref_in = ~ref_in;
    end
  end

  always @(negedge clk) begin
    if (wr_acc === 1'b1) n_acc++;
    if (wr_drop === 1'b1) n_drop++;
    if (wdone === 1'b1) n_wdone++;
  end

  ////////////////////////////////////////
  // checking and control tasks
  task automatic chk(input logic got, input logic exp, input string msg);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask

  task automatic chk_cnt(input int got, input int exp, input string msg);
    compares++;
    if (got != exp) begin
      n_errors++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic complete_run();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic wait_rst();
    for (int i = 0; i < 100 && core_rst !== 1'b0; i++) @(negedge clk);
    if (core_rst !== 1'b0) begin
      n_errors++;
      $display("MISMATCH %0t reset release timeout", $time);
      complete_run();
    end
  endtask

  task automatic pulse_in(ref logic sig);
    sig = 1'b1;
    cyc(1);
    sig = 1'b0;
    cyc(2);
  endtask

  ////////////////////////////////////////
  // main sequence
  initial begin
    sys_rst = 1'b1;
    hw_rst_l = 1'b1;
    ref_run = 1'b1;
    sleep_req = 1'b0;
    xover = 1'b0;
    speed = 1'b0;
    wake_ev = 1'b0;
    wake_en = 1'b0;
    wake_pol = 1'b1;
    wake_od = 1'b0;
    wake_clr = 1'b0;
    cyc(8);
    chk(core_rst, 1'b1, "core reset in reset");
    chk(wr_allow, 1'b0, "write allow in reset");
    chk(spd100, 1'b1, "speed in reset");
    chk(ref_out, 1'b1, "ref out in reset");
    sys_rst = 1'b0;
    wait_rst();
    chk(spd100, 1'b0, "speed latched low");
    chk(aneg, 1'b0, "autoneg off");
    chk(fdx, 1'b0, "half duplex");
    chk(ref_ok, 1'b1, "reference seen");
    speed = 1'b1;
    cyc(10);
    chk(spd100, 1'b0, "speed held");
    chk(aneg, 1'b0, "autoneg held");
    hw_rst_l = 1'b0;
    cyc(4);
    chk(core_rst, 1'b1, "hw reset applied");
    hw_rst_l = 1'b1;
    wait_rst();
    chk(spd100, 1'b1, "speed latched high");
    chk(aneg, 1'b1, "autoneg on");
    chk(fdx, 1'b0, "still half duplex");
    speed = 1'b0;
    cyc(10);
    chk(spd100, 1'b1, "speed held high");
    xover = 1'b1;
    cyc(5);
    chk(xen, 1'b1, "crossover on");
    xover = 1'b0;
    cyc(5);
    chk(xen, 1'b0, "crossover off");
    // write gating
    i_host.access(1'b1, 4);
    chk_cnt(n_drop, 1, "write before read dropped");
    chk_cnt(n_acc, 0, "write before read accepted");
    i_host.first_read();
    chk(wr_allow, 1'b1, "read opens writes");
    i_host.access(1'b1, 4);
    chk_cnt(n_acc, 1, "write accepted");
    i_host.access(1'b1, 12);
    chk_cnt(n_acc, 2, "slow write one pulse");
    // wake indicator and power saving
    pulse_in(wake_ev);
    chk(ind_o, 1'b0, "indicator while disabled");
    pulse_in(sleep_req);
    chk(psave, 1'b1, "sleep entered");
    wake_en = 1'b1;
    pulse_in(wake_ev);
    chk(ind_o, 1'b1, "indicator set");
    cyc(20);
    chk(psave, 1'b1, "event does not wake");
    i_host.access(1'b0, 4);
    chk(psave, 1'b1, "read does not wake");
    i_host.wake_write();
    chk(psave, 1'b0, "write wakes");
    chk_cnt(n_wdone, 1, "wake done pulse");
    chk_cnt(n_drop, 2, "wake write dropped");
    chk(wr_allow, 1'b0, "writes gated after wake");
    i_host.access(1'b1, 4);
    chk_cnt(n_drop, 3, "write after wake dropped");
    // polarity and drive kind, set then cleared
    for (int c = 0; c < 2; c++) begin
      for (int k = 0; k < 4; k++) begin
        wake_od = k[1];
        wake_pol = k[0];
        cyc(2);
        lv = logic'(c == 0) ~^ wake_pol;
        chk(ind_o, wake_od ? 1'b0 : lv, "indicator level");
        chk(ind_oe_l, wake_od ? lv : 1'b0, "indicator enable");
      end
      pulse_in(wake_clr);
    end
    // external reset while writes are open
    i_host.first_read();
    chk(wr_allow, 1'b1, "read reopens writes");
    hw_rst_l = 1'b0;
    cyc(4);
    chk(wr_allow, 1'b0, "reset clears write allow");
    hw_rst_l = 1'b1;
    wait_rst();
    ref_run = 1'b0;
    cyc(80);
    chk(ref_ok, 1'b0, "reference loss");
    complete_run();
  end
endmodule

`default_nettype wire
